// ---- fcl_pkg.sv ----
// Purpose: shared constants and types of the fir coefficient loader
// Assumes: 16-bit register port, 27-bit sign-magnitude coefficients
// Notes:   control register 1 layout and status word layout live here
package fcl_pkg;

  // ==========================================================
  // register map and field positions
  localparam logic [15:0] FCL_CTRL1_ADDR = 16'h0001;
  localparam logic [8:0]  FCL_CTRL1_RST  = 9'h01a;   // kept bits 8..0
  localparam int          FCL_LOAD_BIT   = 15;
  localparam int          FCL_STAT_BIT   = 11;
  localparam int          FCL_TAP_LSB    = 5;
  localparam int          FCL_TAP_MSB    = 8;
  localparam int          FCL_KEEP_MSB   = 8;       // 15..9 self-clear
  localparam int          FCL_GOOD_BIT   = 7;       // status and data lsw
  localparam int          FCL_UFILT_BIT  = 5;       // status word

  // ==========================================================
  // coefficient format and counts
  localparam int          FCL_NUM_COEFFS = 48;
  localparam int          FCL_COEF_W     = 27;
  localparam int          FCL_HI_W       = 11;      // sign + mag 25..16
  localparam int          FCL_IDX_W      = 6;
  localparam logic [5:0]  FCL_COEF_STEP  = 6'h06;   // coeffs per code step

  // ==========================================================
  // download sequencer states, one-hot
  typedef enum logic [4:0] {
    FCL_IDLE = 5'h01,
    FCL_HI   = 5'h02,
    FCL_LO   = 5'h04,
    FCL_SUM  = 5'h08,
    FCL_FILL = 5'h10
  } fcl_state_e;

  // odd code n gives (n+1)/2 * 6 half-response coefficients
  function automatic logic [5:0] fcl_tap_coeffs(input logic [3:0] code);
    return (6'(code[3:1]) + 6'h01) * FCL_COEF_STEP;
  endfunction

  // adds both bytes of one bus word to the running checksum
  function automatic logic [15:0] fcl_add_bytes(input logic [15:0] acc,
                                                input logic [15:0] w);
    return acc + {8'h00, w[15:8]} + {8'h00, w[7:0]};
  endfunction

endpackage

// ---- fcl_coef_ram.sv ----
// Purpose: volatile store of downloaded coefficients
// Assumes: one write port, one registered read port, same clock
// Notes:   contents are undefined after power-up; top tracks validity
`timescale 1ns/10ps
module fcl_coef_ram #(
  parameter int WIDTH = 27,
  parameter int DEPTH = 48,
  parameter int AW    = 6
) (
  input  wire logic             clk,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data_q
);
  logic [WIDTH-1:0] mem_r [DEPTH];

  if (DEPTH > (1 << AW)) begin : g_chk
    $error("fcl_coef_ram: DEPTH does not fit AW");
  end

  // ==========================================================
  // write then registered read; no reset on the array itself
  always_ff @(posedge clk) begin
    if (wr_en && (32'(wr_addr) < DEPTH)) begin
      mem_r[wr_addr] <= wr_data;
    end
    rd_data_q <= (32'(rd_addr) < DEPTH) ? mem_r[rd_addr] : '0;
  end
endmodule

// ---- fcl_default_rom.sv ----
// Purpose: built-in 96-tap low-pass half response, sign-magnitude
// Assumes: index 0 is the tap next to the point of symmetry
// Notes:   read data registered; out-of-range index reads zero
`timescale 1ns/10ps
module fcl_default_rom
  import fcl_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic [FCL_IDX_W-1:0]  addr,
  output logic      [FCL_COEF_W-1:0] data_q
);
  // ==========================================================
  // constant table, bit 26 is the sign
  always_ff @(posedge clk) begin
    case (addr)
      6'h00: data_q <= 27'h332bca0; 6'h01: data_q <= 27'h17fa5a0;
      6'h02: data_q <= 27'h444a196; 6'h03: data_q <= 27'h4b62067;
      6'h04: data_q <= 27'h4140c31; 6'h05: data_q <= 27'h06a734e;
      6'h06: data_q <= 27'h031dddb; 6'h07: data_q <= 27'h439e6b2;
      6'h08: data_q <= 27'h4392e4a; 6'h09: data_q <= 27'h01709d9;
      6'h0a: data_q <= 27'h0344ef8; 6'h0b: data_q <= 27'h001397f;
      6'h0c: data_q <= 27'h428c5fc; 6'h0d: data_q <= 27'h4101f74;
      6'h0e: data_q <= 27'h01a92fb; 6'h0f: data_q <= 27'h016ebf8;
      6'h10: data_q <= 27'h40cc178; 6'h11: data_q <= 27'h4175250;
      6'h12: data_q <= 27'h0016dba; 6'h13: data_q <= 27'h0135efe;
      6'h14: data_q <= 27'h006466d; 6'h15: data_q <= 27'h40d2f26;
      6'h16: data_q <= 27'h40a242e; 6'h17: data_q <= 27'h006a139;
      6'h18: data_q <= 27'h00ab1af; 6'h19: data_q <= 27'h401150a;
      6'h1a: data_q <= 27'h408e917; 6'h1b: data_q <= 27'h402af3e;
      6'h1c: data_q <= 27'h005ee3b; 6'h1d: data_q <= 27'h0047c70;
      6'h1e: data_q <= 27'h402cbd2; 6'h1f: data_q <= 27'h4049e05;
      6'h20: data_q <= 27'h0003ea2; 6'h21: data_q <= 27'h003a2eb;
      6'h22: data_q <= 27'h00158ca; 6'h23: data_q <= 27'h4022f65;
      6'h24: data_q <= 27'h401f797; 6'h25: data_q <= 27'h000ca52;
      6'h26: data_q <= 27'h001dc13; 6'h27: data_q <= 27'h000402a;
      6'h28: data_q <= 27'h401619c; 6'h29: data_q <= 27'h400f99b;
      6'h2a: data_q <= 27'h000b0b2; 6'h2b: data_q <= 27'h001c020;
      6'h2c: data_q <= 27'h0018fd5; 6'h2d: data_q <= 27'h000cdbd;
      6'h2e: data_q <= 27'h0003cc7; 6'h2f: data_q <= 27'h00007ab;
      default: data_q <= '0;
    endcase
  end
endmodule

// ---- fcl_loader.sv ----
// Purpose: coefficient download, checksum and status for the fir stage
// Assumes: host writes one word per write strobe, reads one per strobe
// Notes:   filter arithmetic reads coefficients through coef_idx
//
// Functional notes
// - reset selects the built-in 96-tap set of 48 half coefficients
// - coefficients are sign-magnitude, 26 magnitude bits, sign zero positive
// - coefficients arrive centre first, moving outward
// - upper word holds zeros, sign, mag 25..16; lower word mag 15..0
// - checksum is 16-bit sum of all coefficient bytes, sent last
// - device sums the same bytes and sets download good on match
// - code 0000 selects default, odd codes select 6 to 48 coefficients
// - user set is volatile; reset brings back the default set
// - download good flag sits in bit 7 of the status word
// - download good flag also shows during normal data reads
// - after checksum unused positions are zero-filled; host waits
// - load request bit 15, tap code bits 8..5; writes become coefficients
// - status select bit 11 makes the next read return status
// - control bits 15..9 clear themselves after taking effect
`timescale 1ns/10ps
module fcl_loader
  import fcl_pkg::*;
#(
  parameter int MAX_COEFFS = FCL_NUM_COEFFS
) (
  input  wire logic                  ref_clk,
  input  wire logic                  arst_n,
  input  wire logic [15:0]           reg_addr,
  input  wire logic [15:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [15:0]           reg_rdata,
  input  wire logic [15:0]           conv_word,
  input  wire logic [FCL_IDX_W-1:0]  coef_idx,
  output logic      [FCL_COEF_W-1:0] coef_data,
  output logic                       download_good_flag,
  output logic                       user_filter_active,
  output logic                       load_busy,
  output logic      [FCL_KEEP_MSB:0] ctrl_settings
);

  // ==========================================================
  // elaboration check
  if ((MAX_COEFFS < 6) || (MAX_COEFFS > FCL_NUM_COEFFS) ||
      (MAX_COEFFS % 6 != 0)) begin : g_chk
    $error("fcl_loader: MAX_COEFFS must be 6..48 in steps of 6");
  end

  localparam logic [5:0] MAX_C = 6'(MAX_COEFFS);

  // ==========================================================
  // state record
  typedef struct packed {
    fcl_state_e            st;
    logic [FCL_KEEP_MSB:0] ctrl;      // non self-clearing control bits
    logic [5:0]            idx;       // next coefficient position
    logic [5:0]            count;     // coefficients in this download
    logic [FCL_HI_W-1:0]   hi;        // upper word held until lower
    logic [15:0]           sum;       // running byte checksum
    logic                  good;
    logic                  user;      // user set in force
    logic                  stat_pend; // next read returns status
    logic [15:0]           rdata;
    logic                  sel_d;     // user select aligned to memory read
    logic [FCL_COEF_W-1:0] coef;
    logic                  busy;
  } fcl_state_s;

  fcl_state_s s_q;
  fcl_state_s s_d;
  logic [1:0] rst_sync_q;
  logic       rst_n;

  logic                  mem_we;
  logic [5:0]            mem_wa;
  logic [FCL_COEF_W-1:0] mem_wd;
  logic [FCL_COEF_W-1:0] ram_rd;
  logic [FCL_COEF_W-1:0] rom_rd;
  logic [15:0]           status_word;
  logic                  ctrl_wr;
  logic [3:0]            tap_count_code;
  logic                  arm_ok;

  // ==========================================================
  // reset release through two flops
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ==========================================================
  // storage: downloaded set and built-in default set
  fcl_coef_ram #(
    .WIDTH (FCL_COEF_W),
    .DEPTH (FCL_NUM_COEFFS),
    .AW    (FCL_IDX_W)
  ) u_ram (
    .clk       (ref_clk),
    .wr_en     (mem_we),
    .wr_addr   (mem_wa),
    .wr_data   (mem_wd),
    .rd_addr   (coef_idx),
    .rd_data_q (ram_rd)
  );

  fcl_default_rom u_rom (
    .clk    (ref_clk),
    .addr   (coef_idx),
    .data_q (rom_rd)
  );

  // ==========================================================
  // decode of a control register write
  assign ctrl_wr        = reg_wr && (reg_addr == FCL_CTRL1_ADDR);
  assign tap_count_code = reg_wdata[FCL_TAP_MSB:FCL_TAP_LSB];
  // even nonzero codes and lengths beyond storage are refused
  assign arm_ok = tap_count_code[0] &&
                  (fcl_tap_coeffs(tap_count_code) <= MAX_C);

  // status word: good flag, user-filter flag, decimation/bypass bits
  always_comb begin
    status_word                = '0;
    status_word[FCL_GOOD_BIT]  = s_q.good;
    status_word[FCL_UFILT_BIT] = s_q.user;
    status_word[4:0]           = s_q.ctrl[4:0];
  end

  // ==========================================================
  // next state
  always_comb begin
    s_d    = s_q;
    mem_we = 1'b0;
    mem_wa = s_q.idx;
    mem_wd = '0;
    // read data stand for one cycle only
    s_d.rdata = '0;
    if (reg_rd) begin
      if (s_q.stat_pend) begin
        s_d.rdata     = status_word;
        s_d.stat_pend = 1'b0;
      end else begin
        s_d.rdata               = conv_word;
        s_d.rdata[FCL_GOOD_BIT] = s_q.good;
      end
    end
    case (s_q.st)
      FCL_IDLE: begin
        if (ctrl_wr) begin
          // only bits 8..0 are kept; 15..9 act once and vanish
          s_d.ctrl = reg_wdata[FCL_KEEP_MSB:0];
          if (reg_wdata[FCL_STAT_BIT]) begin
            s_d.stat_pend = 1'b1;
          end
          if (reg_wdata[FCL_LOAD_BIT]) begin
            if (tap_count_code == 4'h0) begin
              s_d.user = 1'b0;
            end else if (arm_ok) begin
              s_d.st    = FCL_HI;
              s_d.count = fcl_tap_coeffs(tap_count_code);
              s_d.idx   = '0;
              s_d.sum   = '0;
              s_d.good  = 1'b0;
              // old set leaves service while the ram is rewritten
              s_d.user  = 1'b0;
            end
          end
        end
      end
      FCL_HI: begin
        // any write is coefficient data while armed
        if (reg_wr) begin
          s_d.hi  = reg_wdata[FCL_HI_W-1:0];
          s_d.sum = fcl_add_bytes(s_q.sum, reg_wdata);
          s_d.st  = FCL_LO;
        end
      end
      FCL_LO: begin
        if (reg_wr) begin
          mem_we  = 1'b1;
          mem_wd  = {s_q.hi, reg_wdata};
          s_d.sum = fcl_add_bytes(s_q.sum, reg_wdata);
          s_d.idx = s_q.idx + 6'h01;
          s_d.st  = (s_q.idx == s_q.count - 6'h01) ? FCL_SUM : FCL_HI;
        end
      end
      FCL_SUM: begin
        if (reg_wr) begin
          // a bad sum keeps the default set and a cleared flag
          s_d.good = (reg_wdata == s_q.sum);
          s_d.user = (reg_wdata == s_q.sum);
          s_d.st   = (s_q.count == MAX_C) ? FCL_IDLE : FCL_FILL;
        end
      end
      FCL_FILL: begin
        // unused outer taps become zero; writes meanwhile are dropped
        mem_we  = 1'b1;
        s_d.idx = s_q.idx + 6'h01;
        if (s_q.idx == MAX_C - 6'h01) begin
          s_d.st = FCL_IDLE;
        end
      end
      default: begin
        s_d.st = FCL_IDLE;
      end
    endcase
    s_d.busy  = (s_d.st != FCL_IDLE);
    // memory reads take one cycle, the select follows them
    s_d.sel_d = s_q.user;
    s_d.coef  = s_q.sel_d ? ram_rd : rom_rd;
  end

  // ==========================================================
  // state register; reset restores default set and control
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q           <= '0;
      s_q.st        <= FCL_IDLE;
      s_q.ctrl      <= FCL_CTRL1_RST;
      s_q.user      <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata          = s_q.rdata;
  assign coef_data          = s_q.coef;
  assign download_good_flag = s_q.good;
  assign user_filter_active = s_q.user;
  assign load_busy          = s_q.busy;
  assign ctrl_settings      = s_q.ctrl;

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  chk_user_needs_good: assert property (
    s_q.user |-> s_q.good)
    else $error("user set in force without good checksum");

  chk_arm_decode: assert property (
    (s_q.st == FCL_IDLE) && ctrl_wr && reg_wdata[15] &&
    reg_wdata[5] && (reg_wdata[8:6] == 3'h1)
    |=> (s_q.st == FCL_HI) && (s_q.count == 6'h0c) && !s_q.good)
    else $error("code 0011 did not arm for 12 coefficients");

  chk_word_pair: assert property (
    (s_q.st == FCL_HI) && reg_wr
    |=> (s_q.st == FCL_LO) && (s_q.hi == $past(reg_wdata[10:0])))
    else $error("upper word not held for its lower word");

  chk_coef_order: assert property (
    (s_q.st == FCL_LO) && reg_wr
    |-> mem_we ##1 (s_q.idx == $past(s_q.idx) + 6'h01))
    else $error("coefficient position did not step outward");

  chk_sum_match: assert property (
    (s_q.st == FCL_SUM) && reg_wr && (reg_wdata == s_q.sum)
    |=> s_q.good && s_q.user)
    else $error("matching checksum not flagged good");

  chk_sum_miss: assert property (
    (s_q.st == FCL_SUM) && reg_wr && (reg_wdata != s_q.sum)
    |=> !s_q.good [*2])
    else $error("bad checksum flagged good");

  chk_fill_ends: assert property (
    (s_q.st == FCL_SUM) && reg_wr && (s_q.count != MAX_C)
    |=> load_busy ##[1:48] !load_busy)
    else $error("zero fill did not finish in time");

  chk_status_read: assert property (
    reg_rd && s_q.stat_pend
    |=> (reg_rdata[7] == $past(s_q.good)) && !s_q.stat_pend)
    else $error("status read wrong or select not cleared");

  chk_data_flag: assert property (
    reg_rd && !s_q.stat_pend |=> reg_rdata[7] == $past(s_q.good))
    else $error("good flag missing from data read");

  chk_read_once: assert property (
    !reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data stood beyond one cycle");

  // ==========================================================
  // control decode, status word, checksum and fill checks
  chk_arm_user_off: assert property (
    (s_q.st == FCL_IDLE) && ctrl_wr && reg_wdata[FCL_LOAD_BIT] && arm_ok
    |=> !s_q.user && !s_q.good && load_busy)
    else $error("arming left the old set or good flag in force");

  chk_even_refused: assert property (
    (s_q.st == FCL_IDLE) && ctrl_wr && reg_wdata[FCL_LOAD_BIT] &&
    !reg_wdata[FCL_TAP_LSB]
    |=> (s_q.st == FCL_IDLE) && !load_busy)
    else $error("even or zero tap code armed a download");

  chk_zero_code: assert property (
    (s_q.st == FCL_IDLE) && ctrl_wr && reg_wdata[FCL_LOAD_BIT] &&
    (reg_wdata[FCL_TAP_MSB:FCL_TAP_LSB] == 4'h0)
    |=> !s_q.user)
    else $error("code 0000 did not restore the default set");

  chk_ctrl_keep: assert property (
    (s_q.st == FCL_IDLE) && ctrl_wr
    |=> ctrl_settings == $past(reg_wdata[FCL_KEEP_MSB:0]))
    else $error("kept control bits not taken from the write");

  chk_fill_zero: assert property (
    (s_q.st == FCL_FILL)
    |-> mem_we && (mem_wd == '0) && (mem_wa >= s_q.count))
    else $error("zero fill touched a downloaded position");

  chk_status_word: assert property (
    reg_rd && s_q.stat_pend
    |=> (reg_rdata[15:8] == 8'h00) && (reg_rdata[5] == $past(s_q.user)) &&
        (reg_rdata[4:0] == $past(s_q.ctrl[4:0])))
    else $error("status word layout wrong");

  chk_sum_step: assert property (
    ((s_q.st == FCL_HI) || (s_q.st == FCL_LO)) && reg_wr
    |=> s_q.sum == $past(s_q.sum + {8'h00, reg_wdata[15:8]} +
                         {8'h00, reg_wdata[7:0]}))
    else $error("checksum did not add both bytes of a word");

  cov_good_load: cover property (
    (s_q.st == FCL_SUM) && reg_wr && (reg_wdata == s_q.sum));
  cov_bad_load: cover property (
    (s_q.st == FCL_SUM) && reg_wr && (reg_wdata != s_q.sum));
  cov_fill: cover property ((s_q.st == FCL_FILL) ##1 (s_q.st == FCL_IDLE));
  cov_status: cover property (reg_rd && s_q.stat_pend);

endmodule

// ---- fcl_host_model.sv ----
// Purpose: host controller model on the loader register port
// Assumes: each task is entered just after a rising edge
// Notes:   idle bus shows inverted last values, never a stale copy
`timescale 1ns/10ps
module fcl_host_model
  import fcl_pkg::*;
(
  input  wire logic        ref_clk,
  output logic      [15:0] reg_addr,
  output logic      [15:0] reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  input  wire logic [15:0] reg_rdata
);
  logic [15:0] last_sum;   // checksum built by the latest download

  // ==========================================================
  // bus cycles
  initial begin
    reg_addr  = 16'h0000;
    reg_wdata = 16'h0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // one write then a gap cycle, so a strobe is never set twice at once
  task wr(input logic [15:0] a, input logic [15:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
    @(posedge ref_clk);
  endtask

  // read data stand only in the cycle after the strobe
  task rd(output logic [15:0] d);
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge ref_clk);
  endtask

  // ==========================================================
  // download; a nonzero flip spoils the checksum on purpose
  // gain scaling of the half-set is not modelled: loader ignores it
  task load(input logic [3:0] code, input logic [26:0] c [48],
            input int n, input logic [15:0] flip);
    logic [15:0] hi;
    logic [15:0] lo;
    logic [15:0] s;
    s = 16'h0000;
    wr(FCL_CTRL1_ADDR, {7'h40, code, 5'h19});
    for (int i = 0; i < n; i++) begin
      hi = {5'h00, c[i][26:16]};
      lo = c[i][15:0];
      s = s + {8'h00, hi[15:8]} + {8'h00, hi[7:0]}
            + {8'h00, lo[15:8]} + {8'h00, lo[7:0]};
      wr(FCL_CTRL1_ADDR, hi);
      wr(FCL_CTRL1_ADDR, lo);
    end
    last_sum = s;
    wr(FCL_CTRL1_ADDR, s ^ flip);
  endtask

  // status select keeps tap code and decimation fields as they are
  task status(input logic [8:0] keep, output logic [15:0] d);
    wr(FCL_CTRL1_ADDR, {4'h0, 1'b1, 2'b00, keep});
    rd(d);
  endtask
endmodule

// ---- fcl_loader_tb_top.sv ----
// Purpose: self-checking bench of the fir coefficient loader
// Assumes: host model owns the register port
// Notes:   random coefficients come from a fixed-seed lfsr
`timescale 1ns/10ps
module fcl_loader_tb_top
  import fcl_pkg::*;
;
  logic        ref_clk;
  logic        arst_n;
  logic [15:0] reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic [15:0] conv_word;
  logic [5:0]  coef_idx;
  logic [26:0] coef_data;
  logic        download_good_flag;
  logic        user_filter_active;
  logic        load_busy;
  logic [8:0]  ctrl_settings;
  int          errors;
  int          checks_done;
  int          n;
  int          gsum;
  logic [31:0] lfsr_q;
  logic [26:0] cset [48];
  logic [15:0] rdat;
  logic [26:0] cdat;
  localparam logic [26:0] DEF0 = 27'h332bca0;
  localparam logic [26:0] EX_C [12] = '{27'h32b9688, 27'h1bf183c,
    27'h0156626, 27'h4a81e6a, 27'h45f2a96, 27'h02c49c2, 27'h050e9f6,
    27'h010dbd8, 27'h42fde54, 27'h437445a, 27'h41b7d6e, 27'h4043b5f};

  fcl_loader fcl_loader_inst (.ref_clk(ref_clk), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_word(conv_word),
    .coef_idx(coef_idx), .coef_data(coef_data),
    .download_good_flag(download_good_flag),
    .user_filter_active(user_filter_active), .load_busy(load_busy),
    .ctrl_settings(ctrl_settings));
  fcl_host_model fcl_host_model_inst (.ref_clk(ref_clk),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  // ==========================================================
  // clock, expectations and compares
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h00000000);
  endfunction

  // status word: good at 7, user set at 5, low control bits below
  function automatic logic [15:0] stat_w(input logic g, input logic u,
                                         input logic [4:0] l);
    return {8'h00, g, 1'b0, u, l};
  endfunction

  task chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task chk_coef(input string nm, input logic [26:0] e, input logic [26:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task chk_bit(input string nm, input logic e, input logic g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask

  task end_sim();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ==========================================================
  // helpers
  task do_reset(input int cyc);
    arst_n <= 1'b0;
    repeat (cyc) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
  endtask

  // coefficient appears two edges after the index is taken
  task get_coef(input logic [5:0] i, output logic [26:0] d);
    coef_idx <= i;
    repeat (3) @(posedge ref_clk);
    #1 d = coef_data;
  endtask

  // bounded wait: fill time is unspecified, so allow a margin
  task wait_idle();
    int k;
    k = 0;
    while (load_busy !== 1'b0 && k < 200) begin
      @(posedge ref_clk);
      #1 k++;
    end
    chk_bit("load_busy", 1'b0, load_busy);
    if (k >= 200) end_sim();
  endtask

  task check_set(input int cnt);
    get_coef(6'h00, cdat);
    chk_coef("coef first", cset[0], cdat);
    get_coef(6'(cnt - 1), cdat);
    chk_coef("coef last", cset[cnt-1], cdat);
    if (cnt < 48) begin
      get_coef(6'(cnt), cdat);
      chk_coef("coef fill", 27'h0000000, cdat);
    end
  endtask

  task data_read(input logic g);
    lfsr_q = lfsr_next(lfsr_q);
    conv_word <= lfsr_q[15:0];
    @(posedge ref_clk);
    fcl_host_model_inst.rd(rdat);
    chk_word("data", {conv_word[15:8], g, conv_word[6:0]}, rdat);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    arst_n      = 1'b0;
    conv_word   = 16'h0000;
    coef_idx    = 6'h00;
    errors      = 0;
    checks_done = 0;
    lfsr_q      = 32'h5e30bf0d;
    do_reset(12);
    #1 chk_bit("good", 1'b0, download_good_flag);
    chk_bit("user", 1'b0, user_filter_active);
    get_coef(6'h00, cdat);
    chk_coef("default first", DEF0, cdat);
    get_coef(6'h2f, cdat);
    chk_coef("default last", 27'h00007ab, cdat);
    fcl_host_model_inst.wr(16'h0002, 16'hffff);
    #1 chk_word("ctrl", 16'h001a, {7'h00, ctrl_settings});
    fcl_host_model_inst.status(9'h01a, rdat);
    chk_word("status", stat_w(1'b0, 1'b0, 5'h1a), rdat);
    data_read(1'b0);
    $display("test reset done");
    // published 24-tap example, checksum computed by the host
    for (int i = 0; i < 48; i++) cset[i] = (i < 12) ? EX_C[i] : 27'h0;
    gsum = 0;
    for (int i = 0; i < 12; i++)
      gsum += EX_C[i][26] ? -int'(EX_C[i][25:0]) : int'(EX_C[i][25:0]);
    chk_coef("example gain", 27'h3ffffff, 27'(gsum));
    fcl_host_model_inst.load(4'h3, cset, 12, 16'h0000);
    chk_word("example sum", 16'h0e6b, fcl_host_model_inst.last_sum);
    #1 chk_bit("busy", 1'b1, load_busy);
    wait_idle();
    chk_bit("good", 1'b1, download_good_flag);
    chk_bit("user", 1'b1, user_filter_active);
    chk_word("ctrl", 16'h0079, {7'h00, ctrl_settings});
    check_set(12);
    fcl_host_model_inst.status(9'h079, rdat);
    chk_word("status", stat_w(1'b1, 1'b1, 5'h19), rdat);
    data_read(1'b1);
    $display("test example done");
    // every odd tap code with random coefficients
    for (int code = 1; code < 16; code += 2) begin
      n = 6 * (code / 2 + 1);
      for (int i = 0; i < 48; i++) begin
        lfsr_q = lfsr_next(lfsr_q);
        cset[i] = lfsr_q[26:0];
      end
      fcl_host_model_inst.load(4'(code), cset, n, 16'h0000);
      wait_idle();
      chk_bit("good", 1'b1, download_good_flag);
      check_set(n);
    end
    $display("test codes done");
    // spoiled checksum keeps the default set
    fcl_host_model_inst.load(4'hf, cset, 48, 16'h0001);
    wait_idle();
    chk_bit("good", 1'b0, download_good_flag);
    chk_bit("user", 1'b0, user_filter_active);
    get_coef(6'h00, cdat);
    chk_coef("coef", DEF0, cdat);
    fcl_host_model_inst.status(9'h1f9, rdat);
    chk_word("status", stat_w(1'b0, 1'b0, 5'h19), rdat);
    $display("test bad sum done");
    // even code does not arm; code zero goes back to default
    fcl_host_model_inst.wr(FCL_CTRL1_ADDR, {7'h40, 4'h4, 5'h19});
    #1 chk_bit("busy", 1'b0, load_busy);
    fcl_host_model_inst.load(4'h1, cset, 6, 16'h0000);
    wait_idle();
    chk_bit("good", 1'b1, download_good_flag);
    fcl_host_model_inst.wr(FCL_CTRL1_ADDR, {7'h40, 4'h0, 5'h19});
    #1 chk_bit("user", 1'b0, user_filter_active);
    get_coef(6'h00, cdat);
    chk_coef("coef", DEF0, cdat);
    $display("test codes edge done");
    // reset in the middle of the fill
    fcl_host_model_inst.load(4'h1, cset, 6, 16'h0000);
    do_reset(2);
    #1 chk_bit("busy", 1'b0, load_busy);
    chk_bit("good", 1'b0, download_good_flag);
    chk_bit("user", 1'b0, user_filter_active);
    get_coef(6'h00, cdat);
    chk_coef("coef", DEF0, cdat);
    $display("test reset mid fill done");
    end_sim();
  end
endmodule
